// *** rtl/atp_pkg.sv ***
package atp_pkg;
   // Wishbone side
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RES = 8'h04;
   localparam logic [7:0] OFS_MISS = 8'h08;
   localparam logic [7:0] OFS_STPT = 8'h0C;
   localparam logic [7:0] OFS_PER = 8'h10;
   localparam logic [7:0] OFS_PHS = 8'h14;
   localparam logic [7:0] OFS_ERR = 8'h18;
   localparam logic [7:0] OFS_FLAGS = 8'h1C;
   localparam logic [7:0] OFS_CMP = 8'h20;
   localparam logic [7:0] OFS_CAP = 8'h24;
   // Field widths
   localparam int PER_W = 16;
   localparam int PHS_W = 10;
   localparam int RES_W = 10;
   localparam int STPT_W = 15;
   localparam int ERR_W = 16;
   localparam int CTRL_W = 7;
   localparam int FLG_W = 5;
   // Control bit positions
   localparam int CTRL_EN = 0;
   localparam int CTRL_MULTI = 1;
   localparam int CTRL_ADAPT = 2;
   localparam int CTRL_PHP = 3;
   localparam int CTRL_PRP = 4;
   localparam int CTRL_MPP = 5;
   localparam int CTRL_CAPP = 6;
   // Flag bit positions, valid is read-only
   localparam int FLG_PHS = 0;
   localparam int FLG_PER = 1;
   localparam int FLG_MISS = 2;
   localparam int FLG_CMP = 3;
   localparam int FLG_CAP = 4;
   localparam int FLG_VALID = 8;
   // Reset values and limits
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
   localparam logic [RES_W-1:0] RES_RST = 10'h000;
   localparam logic [PER_W-1:0] MISS_RST = 16'h0000;
   localparam logic [STPT_W-1:0] STPT_RST = 15'h0000;
   localparam logic [PHS_W-1:0] CMP_RST = 10'h000;
   localparam logic [PHS_W-1:0] PHS_MAX = 10'h3FF;
   localparam logic [1:0] EDGES_TO_VALID = 2'h2;
endpackage : atp_pkg

// *** rtl/atp_divider.sv ***
`timescale 1ns/1ps
module atp_divider #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic clr,
   input wire logic [W-1:0] limit,
   // Result
   output logic tick
);
   logic [W-1:0] cntFf;
   logic [W-1:0] nxt_cnt;

   // Counts zero too, so the ratio is limit plus one
   assign tick = run & ~clr & (cntFf == limit);

   always_comb begin
      nxt_cnt = cntFf;
      if (clr || !run) begin
         nxt_cnt = '0;
      end else if (cntFf >= limit) begin
         nxt_cnt = '0;
      end else begin
         nxt_cnt = cntFf + W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cntFf <= '0;
      end else begin
         cntFf <= nxt_cnt;
      end
   end
endmodule : atp_divider

// *** rtl/atp_angular_timer.sv ***
`timescale 1ns/1ps
module atp_angular_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [atp_pkg::ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [atp_pkg::DAT_W-1:0] dat_i,
   output logic [atp_pkg::DAT_W-1:0] dat_o,
   output logic ack_o,
   // Pulse and capture inputs
   input wire logic pulseIn,
   input wire logic capIn,
   // Event outputs
   output logic phsClkOut,
   output logic perClkOut,
   output logic missOut,
   output logic cmpOut,
   output logic capOut,
   output logic validOut
);
   import atp_pkg::*;

   logic [CTRL_W-1:0] ctrlFf, nxt_ctrl;
   logic [RES_W-1:0] resFf, nxt_res;
   logic [PER_W-1:0] missFf, nxt_miss;
   logic [STPT_W-1:0] stptFf, nxt_stpt;
   logic [PHS_W-1:0] cmpFf, nxt_cmp;
   logic ackFf, nxt_ack;
   logic [DAT_W-1:0] datFf, nxt_dat;
   logic [FLG_W-1:0] w1c;
   logic resWrite;
   logic [DAT_W-1:0] mask;

   logic pSync1Ff, pSync2Ff, pSync3Ff;
   logic cSync1Ff, cSync2Ff, cSync3Ff;
   logic [PER_W-1:0] perCntFf, nxt_perCnt;
   logic [PER_W-1:0] perLatchFf, nxt_perLatch;
   logic [PHS_W-1:0] phsCntFf, nxt_phsCnt;
   logic missSeenFf, nxt_missSeen;
   logic [1:0] edgeCntFf, nxt_edgeCnt;
   logic validFf, nxt_valid;
   logic [FLG_W-1:0] flagsFf, nxt_flags;
   logic [ERR_W-1:0] errFf, nxt_err;
   logic [PHS_W-1:0] capFf, nxt_cap;
   logic phsOutFf, perOutFf, missOutFf, cmpOutFf, capOutFf;
   logic nxt_phsOut, nxt_perOut, nxt_missOut, nxt_cmpOut, nxt_capOut;

   logic en, multi, adapt, pEdge, cEdge, resTick, phsTick;
   logic latchEvt, perEvtRaw, perEvt, missHit, cmpHit, capHit, ovf;
   logic [PER_W-1:0] nxtDiff, thr;

   function automatic logic [DAT_W-1:0] byteMask(input logic [3:0] s);
      logic [DAT_W-1:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{s[i]}};
      end
      return m;
   endfunction : byteMask

   assign en = ctrlFf[CTRL_EN];
   assign multi = ctrlFf[CTRL_MULTI];
   assign adapt = ctrlFf[CTRL_ADAPT];
   assign ack_o = ackFf;
   assign dat_o = datFf;
   assign phsClkOut = phsOutFf;
   assign perClkOut = perOutFf;
   assign missOut = missOutFf;
   assign cmpOut = cmpOutFf;
   assign capOut = capOutFf;
   assign validOut = validFf;

   // Bus group: ack one cycle after the request, write lands at the ack edge
   always_comb begin
      mask = byteMask(sel_i);
      nxt_ack = cyc_i & stb_i & ~ackFf;
      nxt_dat = datFf;
      nxt_ctrl = ctrlFf;
      nxt_res = resFf;
      nxt_miss = missFf;
      nxt_stpt = stptFf;
      nxt_cmp = cmpFf;
      w1c = '0;
      resWrite = 1'b0;
      if (nxt_ack && !we_i) begin
         nxt_dat = '0;
         case ({adr_i[7:2], 2'b00})
            OFS_CTRL: nxt_dat[CTRL_W-1:0] = ctrlFf;
            OFS_RES: nxt_dat[RES_W-1:0] = resFf;
            OFS_MISS: nxt_dat[PER_W-1:0] = missFf;
            OFS_STPT: nxt_dat[STPT_W-1:0] = stptFf;
            OFS_PER: nxt_dat[PER_W-1:0] = perLatchFf;
            OFS_PHS: nxt_dat[PHS_W-1:0] = phsCntFf;
            OFS_ERR: nxt_dat[ERR_W-1:0] = errFf;
            OFS_FLAGS: begin
               nxt_dat[FLG_W-1:0] = flagsFf;
               nxt_dat[FLG_VALID] = validFf;
            end
            OFS_CMP: nxt_dat[PHS_W-1:0] = cmpFf;
            OFS_CAP: nxt_dat[PHS_W-1:0] = capFf;
            default: nxt_dat = '0;
         endcase
      end
      if (cyc_i && stb_i && ackFf && we_i) begin
         case ({adr_i[7:2], 2'b00})
            OFS_CTRL: nxt_ctrl = (ctrlFf & ~mask[CTRL_W-1:0]) | (dat_i[CTRL_W-1:0] & mask[CTRL_W-1:0]);
            OFS_RES: begin
               nxt_res = (resFf & ~mask[RES_W-1:0]) | (dat_i[RES_W-1:0] & mask[RES_W-1:0]);
               resWrite = |sel_i[1:0];
            end
            OFS_MISS: nxt_miss = (missFf & ~mask[PER_W-1:0]) | (dat_i[PER_W-1:0] & mask[PER_W-1:0]);
            OFS_STPT: nxt_stpt = (stptFf & ~mask[STPT_W-1:0]) | (dat_i[STPT_W-1:0] & mask[STPT_W-1:0]);
            OFS_FLAGS: w1c = dat_i[FLG_W-1:0] & mask[FLG_W-1:0];
            OFS_CMP: nxt_cmp = (cmpFf & ~mask[PHS_W-1:0]) | (dat_i[PHS_W-1:0] & mask[PHS_W-1:0]);
            default: nxt_ctrl = ctrlFf;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ackFf <= 1'b0;
         datFf <= '0;
         ctrlFf <= CTRL_RST;
         resFf <= RES_RST;
         missFf <= MISS_RST;
         stptFf <= STPT_RST;
         cmpFf <= CMP_RST;
      end else begin
         ackFf <= nxt_ack;
         datFf <= nxt_dat;
         ctrlFf <= nxt_ctrl;
         resFf <= nxt_res;
         missFf <= nxt_miss;
         stptFf <= nxt_stpt;
         cmpFf <= nxt_cmp;
      end
   end

   // Period divider and phase divider share one counter design
   atp_divider #(.W(RES_W)) uResDiv (
      .clk(clk),
      .rst_n(rst_n),
      .run(en),
      .clr(latchEvt),
      .limit(resFf),
      .tick(resTick)
   );
   atp_divider #(.W(PER_W)) uPhsDiv (
      .clk(clk),
      .rst_n(rst_n),
      .run(en & validFf),
      .clr(latchEvt),
      .limit(perLatchFf),
      .tick(phsTick)
   );

   // Core group
   always_comb begin
      pEdge = pSync2Ff & ~pSync3Ff;
      cEdge = (cSync2Ff ^ ctrlFf[CTRL_CAPP]) & ~(cSync3Ff ^ ctrlFf[CTRL_CAPP]);
      // Every edge latches while invalid; in multi-pulse mode, after a miss the next pulse does not
      latchEvt = en & pEdge & (~validFf | ~multi | ~missSeenFf);
      perEvtRaw = en & pEdge & (~multi | missSeenFf);
      perEvt = perEvtRaw & validFf;
      thr = adapt ? {1'b0, perLatchFf[PER_W-1:1]} : missFf;
      nxtDiff = perCntFf + 16'h0001 - perLatchFf;
      missHit = en & resTick & ~pEdge & (perCntFf >= perLatchFf) & (nxtDiff == thr);
      ovf = validFf & phsTick & ~perEvt & (phsCntFf == PHS_MAX);
      cmpHit = validFf & phsTick & ~perEvt & ((phsCntFf + 10'h001) == cmpFf);
      capHit = validFf & en & cEdge;

      nxt_perCnt = perCntFf;
      nxt_perLatch = perLatchFf;
      nxt_err = errFf;
      if (!en) begin
         nxt_perCnt = '0;
      end else if (latchEvt) begin
         nxt_perCnt = '0;
         nxt_perLatch = perCntFf;
         nxt_err = {1'b0, perCntFf[STPT_W-1:0]} - {1'b0, stptFf};
      end else if (resTick) begin
         nxt_perCnt = perCntFf + 16'h0001;
      end

      nxt_missSeen = missSeenFf;
      if (!en || pEdge) begin
         nxt_missSeen = 1'b0;
      end
      if (missHit) begin
         nxt_missSeen = 1'b1;
      end

      nxt_phsCnt = phsCntFf;
      if (!en || perEvt) begin
         nxt_phsCnt = '0;
      end else if (validFf && phsTick) begin
         nxt_phsCnt = phsCntFf + 10'h001;
      end

      nxt_edgeCnt = edgeCntFf;
      nxt_valid = validFf;
      if (latchEvt && !validFf && edgeCntFf != 2'h3) begin
         nxt_edgeCnt = edgeCntFf + 2'h1;
      end
      if (!validFf && edgeCntFf >= EDGES_TO_VALID) begin
         // Multi-pulse also needs a whole revolution, seen as a miss
         if ((!multi && latchEvt) || (multi && pEdge && missSeenFf)) begin
            nxt_valid = 1'b1;
         end
      end
      // Judge the period being latched now, so the first latching edge counts
      if (!en || resWrite || ovf || nxt_perLatch == '0) begin
         nxt_valid = 1'b0;
         nxt_edgeCnt = '0;
      end

      nxt_cap = capHit ? phsCntFf : capFf;
      // Set beats a same-cycle software clear
      nxt_flags = flagsFf & ~w1c;
      nxt_flags[FLG_PHS] = nxt_flags[FLG_PHS] | (validFf & phsTick);
      nxt_flags[FLG_PER] = nxt_flags[FLG_PER] | perEvt;
      nxt_flags[FLG_MISS] = nxt_flags[FLG_MISS] | (missHit & validFf);
      nxt_flags[FLG_CMP] = nxt_flags[FLG_CMP] | cmpHit;
      nxt_flags[FLG_CAP] = nxt_flags[FLG_CAP] | capHit;
      if (!en) begin
         nxt_flags = '0;
      end

      nxt_phsOut = (validFf & phsTick) ^ ctrlFf[CTRL_PHP];
      nxt_perOut = perEvt ^ ctrlFf[CTRL_PRP];
      nxt_missOut = (missHit & validFf) ^ ctrlFf[CTRL_MPP];
      nxt_cmpOut = cmpHit;
      nxt_capOut = capHit;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pSync1Ff <= 1'b0;
         pSync2Ff <= 1'b0;
         pSync3Ff <= 1'b0;
         cSync1Ff <= 1'b0;
         cSync2Ff <= 1'b0;
         cSync3Ff <= 1'b0;
         perCntFf <= '0;
         perLatchFf <= '0;
         phsCntFf <= '0;
         missSeenFf <= 1'b0;
         edgeCntFf <= '0;
         validFf <= 1'b0;
         flagsFf <= '0;
         errFf <= '0;
         capFf <= '0;
         phsOutFf <= 1'b0;
         perOutFf <= 1'b0;
         missOutFf <= 1'b0;
         cmpOutFf <= 1'b0;
         capOutFf <= 1'b0;
      end else begin
         pSync1Ff <= pulseIn;
         pSync2Ff <= pSync1Ff;
         pSync3Ff <= pSync2Ff;
         cSync1Ff <= capIn;
         cSync2Ff <= cSync1Ff;
         cSync3Ff <= cSync2Ff;
         perCntFf <= nxt_perCnt;
         perLatchFf <= nxt_perLatch;
         phsCntFf <= nxt_phsCnt;
         missSeenFf <= nxt_missSeen;
         edgeCntFf <= nxt_edgeCnt;
         validFf <= nxt_valid;
         flagsFf <= nxt_flags;
         errFf <= nxt_err;
         capFf <= nxt_cap;
         phsOutFf <= nxt_phsOut;
         perOutFf <= nxt_perOut;
         missOutFf <= nxt_missOut;
         cmpOutFf <= nxt_cmpOut;
         capOutFf <= nxt_capOut;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_latchEdge;
      en && pEdge && latchEvt;
   endsequence
   sequence s_skipEdge;
      en && multi && validFf && pEdge && missSeenFf;
   endsequence

   property p_perStep;
      en && resTick && !latchEvt |=> perCntFf == $past(perCntFf) + 16'h0001;
   endproperty
   a_perStep: assert property (p_perStep) else $error("period counter missed a step");
   property p_phsStep;
      validFf && phsTick && !perEvt && !ovf && en |=> phsCntFf == $past(phsCntFf) + 10'h001;
   endproperty
   a_phsStep: assert property (p_phsStep) else $error("phase count missed a step");
   property p_phsReset;
      perEvt |=> phsCntFf == '0 && perOutFf != ctrlFf[CTRL_PRP];
   endproperty
   a_phsReset: assert property (p_phsReset) else $error("period event did not restart");
   property p_latch;
      s_latchEdge |=> perLatchFf == $past(perCntFf) && perCntFf == '0;
   endproperty
   a_latch: assert property (p_latch) else $error("period not latched on edge");
   property p_skip;
      s_skipEdge |=> perLatchFf == $past(perLatchFf) ##1 phsCntFf <= 10'h001;
   endproperty
   a_skip: assert property (p_skip) else $error("pulse after miss latched");
   property p_miss;
      missHit && validFf |=> flagsFf[FLG_MISS] && missOutFf != ctrlFf[CTRL_MPP] && missSeenFf;
   endproperty
   a_miss: assert property (p_miss) else $error("missing pulse not reported");
   property p_quiet;
      !validFf && $stable(ctrlFf) |=> phsOutFf == $past(ctrlFf[CTRL_PHP]) && !cmpOutFf;
   endproperty
   a_quiet: assert property (p_quiet) else $error("output while not valid");
   property p_err;
      s_latchEdge |=> errFf == ({1'b0, $past(perCntFf[STPT_W-1:0])} - {1'b0, $past(stptFf)});
   endproperty
   a_err: assert property (p_err) else $error("period error wrong");
   property p_off;
      !en |=> perCntFf == '0 && phsCntFf == '0 && flagsFf == '0 && !validFf;
   endproperty
   a_off: assert property (p_off) else $error("disable left state behind");
   property p_edge;
      $rose(pSync2Ff) && en && !validFf |=> $past(latchEvt);
   endproperty
   a_edge: assert property (p_edge) else $error("synchronised edge not taken");
endmodule : atp_angular_timer

// *** verification/atp_pulse_src.sv ***
`timescale 1ns/1ps
module atp_pulse_src (
   // Clock
   input wire logic clk,
   // Pulse line towards the timer
   output logic pulseOut
);
   int cycleNo;
   int riseCycle;

   initial begin
      pulseOut = 1'b0;
      cycleNo = 0;
      riseCycle = 0;
   end

   always @(posedge clk) begin
      cycleNo <= cycleNo + 1;
   end

   // Teeth high four clocks, so each level lasts well over two clocks
   // A missing tooth is simply a longer gap
   task automatic send(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         pulseOut <= 1'b1;
         riseCycle = cycleNo;
         repeat (4) @(posedge clk);
         pulseOut <= 1'b0;
         repeat (gap - 5) @(posedge clk);
      end
   endtask : send
endmodule : atp_pulse_src

// *** verification/angular_phase_timer_test.sv ***
`timescale 1ns/1ps
module angular_phase_timer_test;
   import atp_pkg::*;
   logic clk;
   logic rstN;
   logic cycI;
   logic stbI;
   logic weI;
   logic [ADR_W-1:0] adrI;
   logic [3:0] selI;
   logic [DAT_W-1:0] datI;
   logic [DAT_W-1:0] datO;
   logic ackO;
   logic pulse;
   logic capIn;
   logic phsClk;
   logic perClk;
   logic missOut;
   logic validOut;
   logic cmpOut;
   logic capOut;
   logic phpIdle;
   logic mppIdle;
   logic [31:0] q;
   logic [31:0] per;
   int failCount;
   int checkCount;
   int phsN;
   int perN;
   int missN;
   int missAt;
   int cmpN;
   int capN;
   logic [7:0] offs [11] = '{OFS_CTRL, OFS_RES, OFS_MISS, OFS_STPT, OFS_PER, OFS_PHS,
                             OFS_ERR, OFS_FLAGS, OFS_CMP, OFS_CAP, 8'h30};

   atp_angular_timer i_atp_angular_timer (
      .clk(clk), .rst_n(rstN), .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI),
      .sel_i(selI), .dat_i(datI), .dat_o(datO), .ack_o(ackO), .pulseIn(pulse),
      .capIn(capIn), .phsClkOut(phsClk), .perClkOut(perClk), .missOut(missOut),
      .cmpOut(cmpOut), .capOut(capOut), .validOut(validOut)
   );

   atp_pulse_src i_atp_pulse_src (.clk(clk), .pulseOut(pulse));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic stopTest();
      if (failCount == 0 && checkCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stopTest

   task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checkCount++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
         failCount++;
         $display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo, hi);
      end
   endtask : chk

   // Classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cycI <= 1'b1;
      stbI <= 1'b1;
      weI <= w;
      adrI <= a;
      datI <= d;
      selI <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (ackO !== 1'b1 && n < 100);
      q = datO;
      if (n >= 100) failCount++;
      cycI <= 1'b0;
      stbI <= 1'b0;
      weI <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic clearCounts();
      phsN = 0;
      perN = 0;
      missN = 0;
      cmpN = 0;
      capN = 0;
   endtask : clearCounts

   // Counts cycles away from the idle level, i.e. event pulses
   always @(posedge clk) begin
      if (rstN === 1'b1) begin
         if (phsClk !== phpIdle) phsN++;
         if (perClk !== 1'b0) perN++;
         if (cmpOut !== 1'b0) cmpN++;
         if (capOut !== 1'b0) capN++;
         if (missOut !== mppIdle) begin
            missN++;
            missAt = i_atp_pulse_src.cycleNo;
         end
      end
   end

   initial begin
      #3000000;
      failCount++;
      stopTest();
   end

   initial begin
      rstN = 1'b0;
      cycI = 1'b0;
      stbI = 1'b0;
      weI = 1'b0;
      adrI = '0;
      selI = 4'h0;
      datI = '0;
      capIn = 1'b0;
      phpIdle = 1'b0;
      mppIdle = 1'b0;
      failCount = 0;
      checkCount = 0;
      clearCounts();
      repeat (12) @(posedge clk);
      rstN <= 1'b1;
      @(posedge clk);
      wb(1'b1, 8'h30, 32'hFFFF_FFFF);
      foreach (offs[i]) begin
         wb(1'b0, offs[i], 32'h0);
         chk(q, 32'h0, 32'h0);
      end
      wb(1'b1, OFS_RES, 32'h3);
      wb(1'b1, OFS_STPT, 32'h3C);
      wb(1'b1, OFS_CTRL, 32'h5);
      // Single mode, adaptive threshold
      i_atp_pulse_src.send(2, 201);
      chk({31'h0, validOut}, 32'h0, 32'h0);
      chk(phsN + perN, 0, 0);
      i_atp_pulse_src.send(1, 201);
      chk({31'h0, validOut}, 32'h1, 32'h1);
      wb(1'b1, OFS_CMP, 32'h2);
      clearCounts();
      i_atp_pulse_src.send(4, 201);
      chk(perN, 4, 4);
      chk(phsN, 12, 12);
      chk(missN, 0, 0);
      chk(cmpN, 4, 4);
      capIn <= 1'b1;
      repeat (6) @(posedge clk);
      chk(capN, 1, 1);
      wb(1'b0, OFS_PER, 32'h0);
      per = q;
      chk(per, 32'd50, 32'd51);
      wb(1'b0, OFS_ERR, 32'h0);
      chk(q, {16'h0, 16'(per - 32'd60)}, {16'h0, 16'(per - 32'd60)});
      wb(1'b0, OFS_FLAGS, 32'h0);
      chk(q & 32'h107, 32'h103, 32'h103);
      i_atp_pulse_src.send(1, 1000);
      chk(missN, 1, 1);
      chk(missAt - i_atp_pulse_src.riseCycle, 290, 320);
      wb(1'b0, OFS_FLAGS, 32'h0);
      chk(q & 32'h4, 32'h4, 32'h4);
      wb(1'b1, OFS_FLAGS, 32'h4);
      wb(1'b0, OFS_FLAGS, 32'h0);
      chk(q & 32'h4, 32'h0, 32'h0);
      // Fixed threshold with inverted phase and miss outputs
      wb(1'b1, OFS_MISS, 32'hA);
      wb(1'b1, OFS_CTRL, 32'h29);
      phpIdle = 1'b1;
      mppIdle = 1'b1;
      i_atp_pulse_src.send(2, 201);
      clearCounts();
      i_atp_pulse_src.send(1, 1000);
      chk(missN, 1, 1);
      chk(missAt - i_atp_pulse_src.riseCycle, 230, 260);
      chk(phsN, 18, 20);
      wb(1'b1, OFS_RES, 32'h3);
      repeat (3) @(posedge clk);
      chk({31'h0, validOut}, 32'h0, 32'h0);
      // Multi-pulse: four teeth then a gap of one missing tooth
      phpIdle = 1'b0;
      mppIdle = 1'b0;
      wb(1'b1, OFS_CTRL, 32'h7);
      repeat (3) begin
         i_atp_pulse_src.send(3, 201);
         i_atp_pulse_src.send(1, 402);
      end
      chk({31'h0, validOut}, 32'h1, 32'h1);
      clearCounts();
      repeat (2) begin
         i_atp_pulse_src.send(3, 201);
         i_atp_pulse_src.send(1, 402);
      end
      chk(perN, 2, 2);
      chk(missN, 2, 2);
      i_atp_pulse_src.send(1, 201);
      wb(1'b0, OFS_PER, 32'h0);
      chk(q, 32'd50, 32'd51);
      wb(1'b1, OFS_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      wb(1'b0, OFS_PHS, 32'h0);
      chk(q, 32'h0, 32'h0);
      stopTest();
   end
endmodule : angular_phase_timer_test
